// [testbench/gsil_net_peer.sv]
// Purpose: far-side model of protocol engine levels and connection events
// Assumes: driven from the bench through its tasks
// Notes:   index lines go inverted once a pulse is over
`default_nettype none
module gsil_net_peer (
  // clock
  input  wire logic       clk,
  // levels
  output logic            proto_active,
  output logic            ip_set,
  output logic            conn_open,
  output logic            link_up,
  output logic            port_act,
  // connection events
  output logic            tmo_pulse,
  output logic            tmo_eo,
  output logic            tmo_tgt,
  output logic      [2:0] tmo_idx,
  output logic            reopen_pulse,
  output logic      [2:0] reopen_idx
);
  timeunit 1ns;
  timeprecision 1ps;
  // quiet at start
  initial begin
    {proto_active, ip_set, conn_open, link_up, port_act} = 5'h0;
    {tmo_pulse, tmo_eo, tmo_tgt, tmo_idx, reopen_pulse, reopen_idx} = 10'h0;
  end
  // levels change right after an edge
  task automatic lvl(input logic [4:0] v);
    @(posedge clk);
    {proto_active, ip_set, conn_open, link_up, port_act} <= v;
  endtask
  // one-cycle timeout report; stale index must not look valid
  task automatic tmo(input logic eo, input logic tgt, input logic [2:0] idx);
    @(posedge clk);
    {tmo_pulse, tmo_eo, tmo_tgt, tmo_idx} <= {1'h1, eo, tgt, idx};
    @(posedge clk);
    {tmo_pulse, tmo_idx} <= {1'h0, ~idx};
  endtask
  // one-cycle re-establish report
  task automatic reopen(input logic [2:0] idx);
    @(posedge clk);
    {reopen_pulse, reopen_idx} <= {1'h1, idx};
    @(posedge clk);
    {reopen_pulse, reopen_idx} <= {1'h0, ~idx};
  endtask
endmodule
`default_nettype wire

// [testbench/gsil_top_monitor.sv]
// Purpose: concurrent checks on the indicator block pins
// Assumes: bound into gsil_top, status inputs synchronous to CLK
// Notes:   led checks allow for the two-flop pattern pipeline
`default_nettype none
`include "gsil_map.svh"
module gsil_top_monitor (
  // clock and reset
  input wire logic       CLK,
  input wire logic       RSTN,
  // module state
  input wire logic [2:0] SYS_MODE,
  input wire logic       PROC_ALARM,
  input wire logic       DIAG_EVENT,
  // network state
  input wire logic       PROTO_ACTIVE,
  input wire logic       IP_SET,
  input wire logic       TMO_PULSE,
  input wire logic       TMO_EXCL_OWNER,
  input wire logic       TMO_TARGET,
  input wire logic       REOPEN_PULSE,
  input wire logic       LINK_UP,
  input wire logic       PORT_ACT,
  // assembly and leds
  input wire logic [7:0] ASM_INSTANCE,
  input wire logic [7:0] ASM_BYTE66,
  input wire logic       MODULE_STATUS_LED_GREEN,
  input wire logic       MODULE_STATUS_LED_RED,
  input wire logic       NETWORK_STATUS_LED_GREEN,
  input wire logic       NETWORK_STATUS_LED_RED,
  input wire logic       LINK_LED,
  input wire logic       ACT_LED
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // one clock domain, so one default
  // ****
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  logic run_m; // run mode decoded once
  assign run_m = (SYS_MODE == `GSIL_MODE_RUN);
  // exclusive-owner target timeout report
  sequence eo_hit_s;
    TMO_PULSE && TMO_EXCL_OWNER && TMO_TARGET;
  endsequence
  // four quiet cycles so the bit reaches the pins
  sequence net_live_s;
    (PROTO_ACTIVE && IP_SET && !REOPEN_PULSE && SYS_MODE != `GSIL_MODE_POWERUP)[*4];
  endsequence
  alarm57_a: assert property (ASM_INSTANCE == `GSIL_ASM_ALARM && run_m && PROC_ALARM
    |=> ASM_BYTE66[7:6] == 2'h3) else $error("alarm bits missing");
  diag167_a: assert property (ASM_INSTANCE == `GSIL_ASM_DIAG && DIAG_EVENT
    |=> ASM_BYTE66[5]) else $error("diag bit missing");
  alarm_gate_a: assert property (!run_m |=> ASM_BYTE66[7:6] == 2'h0)
    else $error("alarm outside run");
  ms_red_a: assert property ((SYS_MODE == `GSIL_MODE_CRIT)[*3]
    |-> MODULE_STATUS_LED_RED && !MODULE_STATUS_LED_GREEN) else $error("critical not red");
  net_off_a: assert property ((!IP_SET && SYS_MODE != `GSIL_MODE_POWERUP)[*3]
    |-> !NETWORK_STATUS_LED_GREEN && !NETWORK_STATUS_LED_RED) else $error("net lit");
  eo_red_a: assert property (eo_hit_s ##1 net_live_s |-> !NETWORK_STATUS_LED_GREEN)
    else $error("net green after timeout");
  link_on_a: assert property (LINK_UP |=> LINK_LED) else $error("link dark");
  act_off_a: assert property (!PORT_ACT |=> !ACT_LED) else $error("act lit");
endmodule
bind gsil_top gsil_top_monitor gsil_top_monitor_inst (.*);
`default_nettype wire

// [testbench/tb_top.sv]
// Purpose: self-checking bench for the status indicator block
// Assumes: apb slave answers in its own time, flash half period shortened
// Notes:   pins sampled at the falling edge, driven after the rising one
`default_nettype none
module tb_top import gsil_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 4; // short flash half period
  // ****
  // design pins
  // ****
  logic        CLK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, se;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, LOG_STAMP, LOCAL_TIME, rd;
  logic [2:0]  SYS_MODE, TMO_IDX, REOPEN_IDX;
  logic [1:0]  PROJ_STATE;
  logic [5:0]  STAT_IDX;
  logic [7:0]  STAT_DATA, ASM_INSTANCE, ASM_BYTE66;
  logic        EXT_ERROR, FAULT_RECOV, FAULT_CRIT, PROC_ALARM, DIAG_EVENT, STAT_WE;
  logic        PROTO_ACTIVE, IP_SET, CONN_OPEN, TMO_PULSE, TMO_EXCL_OWNER, TMO_TARGET;
  logic        REOPEN_PULSE, LINK_UP, PORT_ACT, LINK_LED, ACT_LED, LOCAL_TIME_VALID;
  logic        MODULE_STATUS_LED_GREEN, MODULE_STATUS_LED_RED;
  logic        NETWORK_STATUS_LED_GREEN, NETWORK_STATUS_LED_RED;
  logic [19:0] t;
  int          err_total = 0, n_tests = 0, cyc = 0, i;
  // {mode, project, ext, recov, crit, proto, module pattern}
  logic [11:0] ms_tab [9] = '{12'h105, 12'h203, 12'h284, 12'h503, 12'h701,
                              12'h745, 12'h902, 12'h72C, 12'h71A};
  // {peer levels, network pattern}
  logic [7:0]  ns_tab [3] = '{8'h00, 8'hC3, 8'hE1};
  // {instance, run, alarm, diag, byte 66}
  logic [19:0] as_tab [6] = '{20'h39CC0, 20'h39A00, 20'hA7A20, 20'hA7CE0, 20'hA7400,
                              20'h0AE00};
  gsil_top #(.HALF_CYC(HALF)) gsil_top_inst (.*);
  gsil_net_peer gsil_net_peer_inst (.clk(CLK), .proto_active(PROTO_ACTIVE),
    .ip_set(IP_SET), .conn_open(CONN_OPEN), .link_up(LINK_UP), .port_act(PORT_ACT),
    .tmo_pulse(TMO_PULSE), .tmo_eo(TMO_EXCL_OWNER), .tmo_tgt(TMO_TARGET),
    .tmo_idx(TMO_IDX), .reopen_pulse(REOPEN_PULSE), .reopen_idx(REOPEN_IDX));
  // ****
  // tasks
  // ****
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge CLK);
  endtask
  // one apb transfer; answer taken at the rising edge where pready is high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK);
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'h2, w, a, d};
    @(posedge CLK);
    PENABLE <= 1'h1;
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'h1);
    {rd, se} = {PRDATA, PSLVERR};
    {PSEL, PENABLE} <= 2'h0;
  endtask
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e, m);
    apb(1'h0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask
  task automatic do_reset;
    RSTN <= 1'h0;
    wt(20);
    RSTN <= 1'h1;
  endtask
  // ****
  // clock and hang guard
  // ****
  initial begin
    CLK = 1'h0;
    forever #2 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin // runs well under this
      err_total++;
      results();
    end
  end
  // ****
  // main sequence
  // ****
  initial begin
    RSTN = 1'h0;
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    {SYS_MODE, PROJ_STATE, EXT_ERROR, FAULT_RECOV, FAULT_CRIT, PROC_ALARM, DIAG_EVENT} = '0;
    {STAT_WE, STAT_IDX, STAT_DATA, ASM_INSTANCE} = '0;
    do_reset();
    wt(3);
    rdc("selftest", 12'h010, {25'h0, LED_ALT, 1'h0, LED_ALT}, 32'h77);
    chk("time valid", 32'h0, {31'h0, LOCAL_TIME_VALID});
    foreach (ms_tab[i]) begin
      t = {8'h0, ms_tab[i]};
      gsil_net_peer_inst.lvl({t[3], 4'h8});
      {SYS_MODE, PROJ_STATE, EXT_ERROR, FAULT_RECOV, FAULT_CRIT} <= t[11:4];
      wt(3);
      rdc("ms pattern", 12'h010, {29'h0, t[2:0]}, 32'h7);
      rdc("mode", 12'h000, {29'h0, t[11:9]}, 32'h7);
    end
    {SYS_MODE, EXT_ERROR, FAULT_RECOV, FAULT_CRIT} <= {3'h3, 3'h0};
    foreach (ns_tab[i]) begin
      gsil_net_peer_inst.lvl(ns_tab[i][7:3]);
      wt(3);
      rdc("ns pattern", 12'h010, {25'h0, ns_tab[i][2:0], 4'h0}, 32'h70);
    end
    gsil_net_peer_inst.tmo(1'h1, 1'h1, 3'h2);
    gsil_net_peer_inst.tmo(1'h1, 1'h1, 3'h5);
    wt(3);
    rdc("ns timeout", 12'h010, {25'h0, LED_FLASH_R, 4'h0}, 32'h70);
    rdc("eo vector", 12'h014, 32'h24, 32'hFF);
    gsil_net_peer_inst.reopen(3'h2);
    wt(3);
    rdc("ns one open", 12'h010, {25'h0, LED_FLASH_R, 4'h0}, 32'h70);
    gsil_net_peer_inst.reopen(3'h5);
    gsil_net_peer_inst.tmo(1'h0, 1'h1, 3'h3);
    gsil_net_peer_inst.tmo(1'h1, 1'h0, 3'h4);
    wt(3);
    rdc("ns back", 12'h010, {25'h0, LED_GREEN, 4'h0}, 32'h70);
    rdc("eo clear", 12'h014, 32'h0, 32'hFF);
    gsil_net_peer_inst.lvl(5'h18);
    SYS_MODE <= 3'h2;
    wt(3);
    @(negedge CLK);
    rd[0] = MODULE_STATUS_LED_GREEN;
    chk("flash sync", {31'h0, rd[0]}, {31'h0, NETWORK_STATUS_LED_GREEN});
    repeat (HALF) @(negedge CLK);
    chk("flash half", {31'h0, ~rd[0]}, {31'h0, MODULE_STATUS_LED_GREEN});
    foreach (as_tab[i]) begin
      t = as_tab[i];
      @(posedge CLK);
      {ASM_INSTANCE, PROC_ALARM, DIAG_EVENT} <= {t[19:12], t[10:9]};
      SYS_MODE <= t[11] ? 3'h3 : 3'h2;
      wt(2);
      @(negedge CLK);
      chk("byte66", {24'h0, t[7:0]}, {24'h0, ASM_BYTE66});
      rdc("diag reg", 12'h004, {30'h0, t[10] & t[11], t[9]}, 32'h3);
    end
    STAT_WE <= 1'h1;
    {STAT_IDX, STAT_DATA} <= {6'h00, 8'h5A};
    @(posedge CLK);
    {STAT_IDX, STAT_DATA} <= {6'h3B, 8'hA5};
    @(posedge CLK);
    STAT_WE <= 1'h0;
    rdc("stat first", 12'h100, 32'h5A, 32'hFF);
    rdc("stat last", 12'h1EC, 32'hA5, 32'hFF);
    for (i = 0; i < 2; i++) begin
      gsil_net_peer_inst.lvl(i ? 5'h1D : 5'h1E);
      wt(2);
      @(negedge CLK);
      chk("link act", i ? 32'h1 : 32'h2, {30'h0, LINK_LED, ACT_LED});
    end
    rd = LOG_STAMP;
    repeat (6 * HALF) @(negedge CLK);
    chk("uptime", rd + 32'h3, LOG_STAMP);
    apb(1'h1, 12'h00C, 32'h1234);
    @(negedge CLK);
    chk("local time", 32'h1234, LOCAL_TIME);
    chk("time valid", 32'h1, {31'h0, LOCAL_TIME_VALID});
    apb(1'h1, 12'h000, 32'h5);
    chk("ro refuse", 32'h1, {31'h0, se});
    apb(1'h0, 12'h020, 32'h0);
    chk("unmapped", 32'h8000_0000, {se, rd[30:0]});
    do_reset();
    chk("time dropped", 32'h0, {31'h0, LOCAL_TIME_VALID});
    results();
  end
endmodule
`default_nettype wire

// [verilog/gsil_blink.sv]
// Purpose: shared free-running flash divider
// Assumes: one clock
// Notes:   phase has equal halves; tick pulses once per full period
`default_nettype none
`include "gsil_map.svh"
module gsil_blink #(
  parameter int HALF_CYC = `GSIL_HALF_SEC_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // outputs
  output logic      phase,
  output logic      tick
);
  typedef struct packed {
    logic [31:0] cnt;   // cycles in this half
    logic        ph;    // flash phase
    logic        tk;    // period pulse
  } gsil_blink_t;
  gsil_blink_t s_q, s_d;

  // count halves, pulse at end of second half
  always_comb begin
    s_d = s_q;
    s_d.tk = 1'b0;
    if (s_q.cnt == 32'(HALF_CYC - 1)) begin
      s_d.cnt = `GSIL_RST_WORD;
      s_d.ph  = ~s_q.ph;
      s_d.tk  = s_q.ph;
    end else begin
      s_d.cnt = s_q.cnt + 32'h1;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign phase = s_q.ph;
  assign tick  = s_q.tk;
endmodule
`default_nettype wire

// [verilog/gsil_map.svh]
// Purpose: offsets, codes and bit positions of the indicator block
// Assumes: included by its bare name from every design module
// Notes:   definitions only
`ifndef GSIL_MAP_SVH
`define GSIL_MAP_SVH
// ****************************************
// register byte offsets
// ****************************************
`define GSIL_OFS_MODE      12'h000
`define GSIL_OFS_DIAG      12'h004
`define GSIL_OFS_UPTIME    12'h008
`define GSIL_OFS_LOCALTIME 12'h00C
`define GSIL_OFS_LEDS      12'h010
`define GSIL_OFS_EOTMO     12'h014
`define GSIL_OFS_STAT_LO   12'h100
`define GSIL_OFS_STAT_HI   12'h1EC
// ****************************************
// system mode codes
// ****************************************
`define GSIL_MODE_POWERUP  3'h0
`define GSIL_MODE_INIT     3'h1
`define GSIL_MODE_IDLE     3'h2
`define GSIL_MODE_RUN      3'h3
`define GSIL_MODE_CRIT     3'h4
// ****************************************
// project file codes
// ****************************************
`define GSIL_PROJ_DELETED  2'h0
`define GSIL_PROJ_INVALID  2'h1
`define GSIL_PROJ_VALID    2'h2
// ****************************************
// cyclic assembly
// ****************************************
`define GSIL_ASM_ALARM     8'h39
`define GSIL_ASM_DIAG      8'hA7
`define GSIL_BIT_ALARM_HI  7
`define GSIL_BIT_ALARM_LO  6
`define GSIL_BIT_DIAG      5
// ****************************************
// sizes and reset values
// ****************************************
`define GSIL_STAT_BYTES    60
`define GSIL_HALF_SEC_CYC  125000000
`define GSIL_RST_WORD      32'h0000_0000
`endif

// [verilog/gsil_pkg.sv]
// Purpose: shared types of the indicator block
// Assumes: nothing
// Notes:   numbers live in gsil_map.svh
`default_nettype none
package gsil_pkg;
  // ****************************************
  // led patterns
  // ****************************************
  typedef enum logic [2:0] {
    LED_OFF,
    LED_GREEN,
    LED_RED,
    LED_FLASH_G,
    LED_FLASH_R,
    LED_ALT
  } gsil_led_t;
endpackage
`default_nettype wire

// [verilog/gsil_stmem.sv]
// Purpose: system status byte store
// Assumes: one write and one read port
// Notes:   read data registered, one cycle after the address
`default_nettype none
`include "gsil_map.svh"
module gsil_stmem #(
  parameter int DEPTH = `GSIL_STAT_BYTES,
  parameter int WIDTH = 8,
  parameter int AW    = 6
) (
  // clock
  input  wire logic             clk,
  // write side
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  // read side
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem_q [DEPTH];   // storage, no reset needed
  logic [WIDTH-1:0] rd_q;            // read register

  // write and registered read; out of range reads as zero
  always_ff @(posedge clk) begin
    if (we && (int'(waddr) < DEPTH)) begin
      mem_q[waddr] <= wdata;
    end
    rd_q <= (int'(raddr) < DEPTH) ? mem_q[raddr] : '0;
  end

  assign rdata = rd_q;
endmodule
`default_nettype wire

// [verilog/gsil_top.sv]
// Purpose: gateway status leds, assembly alarm byte, uptime and apb view
// Assumes: status inputs synchronous to CLK, apb slave with no wait states
// Notes:   flashing patterns all share one divider
//          status led pins lag level inputs by two cycles: pattern flop, then pin flop; timeout pulses lag three; link and act leds lag one
//          apb reads are decoded in the setup cycle and held until the next one, except store bytes, re-read from PADDR every cycle
//          only the local time word is writable; every other write is refused
//          the status byte store has no reset; unwritten bytes are undefined
//
// Local design decisions: register access over APB and the placing of the registers.
`default_nettype none
`include "gsil_map.svh"
module gsil_top
  import gsil_pkg::*;
#(
  parameter int N_EO     = 8,
  parameter int EO_W     = 3,
  parameter int HALF_CYC = `GSIL_HALF_SEC_CYC
) (
  // clock and reset
  input  wire logic            CLK,
  input  wire logic            RSTN,
  // apb slave
  input  wire logic            PSEL,
  input  wire logic            PENABLE,
  input  wire logic            PWRITE,
  input  wire logic [11:0]     PADDR,
  input  wire logic [31:0]     PWDATA,
  output logic                 PREADY,
  output logic      [31:0]     PRDATA,
  output logic                 PSLVERR,
  // module state
  input  wire logic [2:0]      SYS_MODE,
  input  wire logic [1:0]      PROJ_STATE,
  input  wire logic            EXT_ERROR,
  input  wire logic            FAULT_RECOV,
  input  wire logic            FAULT_CRIT,
  input  wire logic            PROC_ALARM,
  input  wire logic            DIAG_EVENT,
  // network state
  input  wire logic            PROTO_ACTIVE,
  input  wire logic            IP_SET,
  input  wire logic            CONN_OPEN,
  input  wire logic            TMO_PULSE,
  input  wire logic            TMO_EXCL_OWNER,
  input  wire logic            TMO_TARGET,
  input  wire logic [EO_W-1:0] TMO_IDX,
  input  wire logic            REOPEN_PULSE,
  input  wire logic [EO_W-1:0] REOPEN_IDX,
  input  wire logic            LINK_UP,
  input  wire logic            PORT_ACT,
  // status byte writes
  input  wire logic            STAT_WE,
  input  wire logic [5:0]      STAT_IDX,
  input  wire logic [7:0]      STAT_DATA,
  // assembly selection and byte
  input  wire logic [7:0]      ASM_INSTANCE,
  output logic      [7:0]      ASM_BYTE66,
  // leds
  output logic                 MODULE_STATUS_LED_GREEN,
  output logic                 MODULE_STATUS_LED_RED,
  output logic                 NETWORK_STATUS_LED_GREEN,
  output logic                 NETWORK_STATUS_LED_RED,
  output logic                 LINK_LED,
  output logic                 ACT_LED,
  // diagnostics time
  output logic      [31:0]     LOG_STAMP,
  output logic      [31:0]     LOCAL_TIME,
  output logic                 LOCAL_TIME_VALID
);
  // ****************************************
  // state
  // ****************************************
  // every flop of the block outside the divider and the status store lives in this one struct, so that reset
  // and the next-state copy cannot miss a field
  typedef struct packed {
    gsil_led_t       ms;       // module led pattern
    gsil_led_t       ns;       // network led pattern
    logic [1:0]      ms_gr;    // module led green, red
    logic [1:0]      ns_gr;    // network led green, red
    logic            link;     // link led
    logic            act;      // activity led
    logic [7:0]      asm_b;    // assembly byte
    logic [N_EO-1:0] eo;       // timed-out owner points
    logic [31:0]     uptime;   // powered-on seconds
    logic [31:0]     ltime;    // local time
    logic            lvalid;   // local time set
    logic [31:0]     rdat;     // register read data
    logic            rd_mem;   // read from status store
    logic            err;      // access refused
  } gsil_state_t;
  gsil_state_t s_q, s_d;

  logic       phase;      // shared flash phase
  logic       sec_tick;   // one pulse per second
  logic [7:0] stat_rd;    // status store read data
  logic       alarm;      // alarm as seen outside

  // ****************************************
  // helpers
  // ****************************************
  // address lies in the status byte window
  function automatic logic is_stat(input logic [11:0] a);
    is_stat = (a >= `GSIL_OFS_STAT_LO) && (a <= `GSIL_OFS_STAT_HI);
  endfunction

  // pattern to {green, red} with the shared phase
  // the alternate pattern lights exactly one colour at a time
  function automatic logic [1:0] led_drive(input gsil_led_t p, input logic ph);
    unique case (p)
      LED_OFF:     led_drive = 2'h0;
      LED_GREEN:   led_drive = 2'h2;
      LED_RED:     led_drive = 2'h1;
      LED_FLASH_G: led_drive = {ph, 1'b0};
      LED_FLASH_R: led_drive = {1'b0, ph};
      LED_ALT:     led_drive = {ph, ~ph};
      default:     led_drive = 2'h0;
    endcase
  endfunction

  // ****************************************
  // submodules
  // ****************************************
  // one divider so that every flashing led stays in step
  gsil_blink #(
    .HALF_CYC (HALF_CYC)
  ) u_blink (
    .clk   (CLK),
    .rst_n (RSTN),
    .phase (phase),
    .tick  (sec_tick)
  );

  // status bytes, read during the apb setup cycle
  // addressed straight from the bus so that the registered read data
  // is already standing when the access phase begins
  gsil_stmem u_stmem (
    .clk   (CLK),
    .we    (STAT_WE),
    .waddr (STAT_IDX),
    .wdata (STAT_DATA),
    .raddr (PADDR[7:2]),
    .rdata (stat_rd)
  );

  // alarm is masked whenever the module is not running
  // one masked copy feeds both the assembly byte and the diag word,
  // so the two views of the alarm can never disagree
  assign alarm = PROC_ALARM && (SYS_MODE == `GSIL_MODE_RUN);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;

    // ****************************************
    // module status led
    // ****************************************
    // the order of the tests is the priority: self-test hides every fault,
    // a critical fault hides a recoverable one, a clean run shows green
    // module led, highest cause first
    if (SYS_MODE == `GSIL_MODE_POWERUP) begin
      s_d.ms = LED_ALT;
    end else if (SYS_MODE == `GSIL_MODE_CRIT || (PROTO_ACTIVE && FAULT_CRIT)) begin
      s_d.ms = LED_RED;
    end else if ((SYS_MODE == `GSIL_MODE_INIT && PROJ_STATE == `GSIL_PROJ_INVALID)
                 || (PROTO_ACTIVE && FAULT_RECOV)) begin
      s_d.ms = LED_FLASH_R;
    end else if (SYS_MODE == `GSIL_MODE_RUN && PROJ_STATE == `GSIL_PROJ_VALID) begin
      // external error shown as alternating, the more visible choice
      s_d.ms = EXT_ERROR ? LED_ALT : LED_GREEN;
    end else begin
      // deleted project in init, or idle: not configured
      s_d.ms = LED_FLASH_G;
    end

    // ****************************************
    // network status led
    // ****************************************
    // with ip set and the protocol active, a pending owner timeout outranks an open
    // connection, so the led stays flashing red until every recorded point has been reopened
    // network led
    if (SYS_MODE == `GSIL_MODE_POWERUP) begin
      s_d.ns = LED_ALT;
    end else if (!IP_SET) begin
      s_d.ns = LED_OFF;
    end else if (PROTO_ACTIVE && (s_q.eo != '0)) begin
      s_d.ns = LED_FLASH_R;
    end else if (CONN_OPEN) begin
      s_d.ns = LED_GREEN;
    end else if (PROTO_ACTIVE) begin
      s_d.ns = LED_FLASH_G;
    end else begin
      s_d.ns = LED_OFF; // ip set but protocol down
    end

    // drive pins from the registered patterns
    // the extra pin flop costs a cycle but keeps the decode glitches
    // of the pattern logic away from the led drivers
    s_d.ms_gr = led_drive(s_q.ms, phase);
    s_d.ns_gr = led_drive(s_q.ns, phase);
    s_d.link  = LINK_UP;
    s_d.act   = PORT_ACT;

    // timed-out owner points: reopen clears, a new timeout wins
    // one bit per point, so reopening one point cannot hide another;
    // only timeouts of owner connections aimed at us are recorded,
    // originated and routed connections never reach this vector
    if (REOPEN_PULSE) begin
      s_d.eo[REOPEN_IDX] = 1'b0;
    end
    if (TMO_PULSE && TMO_EXCL_OWNER && TMO_TARGET) begin
      s_d.eo[TMO_IDX] = 1'b1;
    end

    // cyclic assembly byte
    // both alarm bits carry the same value; the diag bit exists only in
    // the larger assembly, any other instance leaves the byte at zero
    // limitation: the byte is rebuilt every cycle, nothing is latched
    s_d.asm_b = 8'h00;
    if (ASM_INSTANCE == `GSIL_ASM_ALARM || ASM_INSTANCE == `GSIL_ASM_DIAG) begin
      s_d.asm_b[`GSIL_BIT_ALARM_HI] = alarm;
      s_d.asm_b[`GSIL_BIT_ALARM_LO] = alarm;
    end
    if (ASM_INSTANCE == `GSIL_ASM_DIAG) begin
      s_d.asm_b[`GSIL_BIT_DIAG] = alarm || DIAG_EVENT;
    end

    // powered-on time; wraps after 136 years
    // counts from reset only, nothing survives a power cycle
    // the same value stamps every diagnostic log entry
    if (sec_tick) begin
      s_d.uptime = s_q.uptime + 32'h1;
    end

    // local time runs with the seconds once set; reset forgets it
    // a write in the cycle of a second tick wins, so a freshly set
    // time is never off by one
    if (PSEL && PENABLE && PWRITE && PADDR == `GSIL_OFS_LOCALTIME) begin
      s_d.ltime  = PWDATA;
      s_d.lvalid = 1'b1;
    end else if (sec_tick && s_q.lvalid) begin
      s_d.ltime = s_q.ltime + 32'h1;
    end

    // read data and refusal decided in the setup cycle
    // deciding early lets the slave answer without wait states; the
    // trade-off is that live inputs are captured one cycle before the
    // access phase, which is harmless for slow status levels
    if (PSEL && !PENABLE) begin
      s_d.rd_mem = is_stat(PADDR) && !PWRITE;
      s_d.err    = 1'b0;
      s_d.rdat   = `GSIL_RST_WORD;
      if (is_stat(PADDR)) begin
        s_d.err = PWRITE;
      end else begin
        unique case (PADDR)
          `GSIL_OFS_MODE: begin
            s_d.rdat = {29'h0, SYS_MODE};
            s_d.err  = PWRITE;
          end
          `GSIL_OFS_DIAG: begin
            s_d.rdat = {30'h0, alarm, DIAG_EVENT};
            s_d.err  = PWRITE;
          end
          `GSIL_OFS_UPTIME: begin
            s_d.rdat = s_q.uptime;
            s_d.err  = PWRITE;
          end
          `GSIL_OFS_LOCALTIME: begin
            s_d.rdat = s_q.ltime;
          end
          `GSIL_OFS_LEDS: begin
            s_d.rdat = {18'h0, s_q.act, s_q.link, s_q.ns_gr, s_q.ms_gr,
                        1'b0, s_q.ns, 1'b0, s_q.ms};
            s_d.err  = PWRITE;
          end
          `GSIL_OFS_EOTMO: begin
            s_d.rdat = 32'(s_q.eo);
            s_d.err  = PWRITE;
          end
          default: begin
            s_d.err = 1'b1; // unmapped
          end
        endcase
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  // reset clears every field at once, which also drops the local time
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // no wait states: every access completes in its first access cycle
  // the refusal only shows while the access phase stands, so an idle
  // bus never sees a stale error
  assign PREADY  = 1'b1;
  assign PRDATA  = s_q.rd_mem ? {24'h0, stat_rd} : s_q.rdat;
  assign PSLVERR = PSEL && PENABLE && s_q.err;

  assign ASM_BYTE66               = s_q.asm_b;
  assign MODULE_STATUS_LED_GREEN  = s_q.ms_gr[1];
  assign MODULE_STATUS_LED_RED    = s_q.ms_gr[0];
  assign NETWORK_STATUS_LED_GREEN = s_q.ns_gr[1];
  assign NETWORK_STATUS_LED_RED   = s_q.ns_gr[0];
  assign LINK_LED                 = s_q.link;
  assign ACT_LED                  = s_q.act;
  assign LOG_STAMP                = s_q.uptime;
  assign LOCAL_TIME               = s_q.ltime;
  assign LOCAL_TIME_VALID         = s_q.lvalid;
endmodule
`default_nettype wire
